// ==== uart_ctrl_consts.svh ====
// Offsets, field positions, reset values and thresholds of the serial port control block.
`ifndef UART_CTRL_CONSTS_SVH
`define UART_CTRL_CONSTS_SVH

`define OFS_PORT_CONTROL 8'h30
`define OFS_TRIGGER_SEL 8'h34
`define OFS_INT_MASK 8'h38
`define OFS_EVT_STATUS 8'h48
`define OFS_MASKED_STATUS 8'h4C
`define OFS_SECTION_STATE 8'h50
`define ADDR_WORD_MASK 8'hFC

`define CR_RXE 9
`define CR_TXE 8
`define CR_LBE 7
`define CR_EN 0
`define RXSEL_MSB 5
`define RXSEL_LSB 3
`define TXSEL_MSB 2
`define TXSEL_LSB 0
`define INT_MSB 10
`define INT_LSB 4
`define INT_W 7

`define CR_RESET 32'h0000_0300
`define TRIG_RESET 32'h0000_0012
`define MASK_RESET 32'h0000_0000
`define CR_WMASK 32'h0000_0381
`define TRIG_WMASK 32'h0000_003F
`define INT_WMASK 32'h0000_07F0

`define SEL_8TH 3'h0
`define SEL_QUARTER 3'h1
`define SEL_HALF 3'h2
`define SEL_3QUARTER 3'h3
`define SEL_7EIGHTH 3'h4
`define LVL_8TH 5'h02
`define LVL_QUARTER 5'h04
`define LVL_HALF 5'h08
`define LVL_3QUARTER 5'h0C
`define LVL_7EIGHTH 5'h0E
`define LVL_EMPTY 5'h00

`endif

// ==== uart_ctrl_pkg.sv ====
// Types shared by the serial port control block.
package uart_ctrl_pkg;

  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic loop;
    logic mod_en;
  } ctrl_t;

  typedef struct packed {
    logic [4:0] level;
    logic [2:0] sel;
  } fifo_view_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } bus_state_t;

endpackage

// ==== level_cross.sv ====
// Detects the fill level of one FIFO passing through its selected trigger point.
`timescale 1ns/1ns
`default_nettype none
`include "uart_ctrl_consts.svh"

module level_cross
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic falling,
  input wire uart_ctrl_pkg::fifo_view_t view,
  output logic hit_r
);

  logic [4:0] thr;
  logic thr_ok;
  logic [4:0] prev_r;
  logic beyond_now;
  logic beyond_prev;
  logic hit_nxt;

  assign thr = (view.sel == `SEL_8TH) ? `LVL_8TH :
               (view.sel == `SEL_QUARTER) ? `LVL_QUARTER :
               (view.sel == `SEL_HALF) ? `LVL_HALF :
               (view.sel == `SEL_3QUARTER) ? `LVL_3QUARTER : `LVL_7EIGHTH;
  // Reserved codes never trigger.
  assign thr_ok = (view.sel <= `SEL_7EIGHTH);

  // Receive triggers at or above the point, transmit at or below it.
  assign beyond_now = falling ? (view.level <= thr) : (view.level >= thr);
  assign beyond_prev = falling ? (prev_r <= thr) : (prev_r >= thr);
  assign hit_nxt = thr_ok && beyond_now && !beyond_prev;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_r <= `LVL_EMPTY;
      hit_r <= 1'b0;
    end
    else
    begin
      prev_r <= view.level;
      hit_r <= hit_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== uart_ctrl_irq.sv ====
// Serial port enables, loopback, FIFO trigger select and interrupt masking with bus slave.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "uart_ctrl_consts.svh"

module uart_ctrl_irq
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic TX_BUSY,
  input wire logic RX_BUSY,
  output logic TX_RUN,
  output logic RX_RUN,
  input wire logic TX_SERIAL,
  output logic RX_SERIAL,
  input wire logic SERIAL_IN_PIN,
  output logic SERIAL_OUT_PIN,
  input wire logic [4:0] TX_LEVEL,
  input wire logic [4:0] RX_LEVEL,
  input wire logic [4:0] ERR_RAW,
  output logic [6:0] MASKED_INT,
  output logic IRQ
);

  // Bus handshake state and decoded strobes.
  uart_ctrl_pkg::bus_state_t state_r;
  uart_ctrl_pkg::bus_state_t state_nxt;
  logic req;
  logic fire;
  logic wr_fire;
  logic [7:0] word_addr;
  logic sel_cr;
  logic sel_trig;
  logic sel_mask;
  logic sel_evt;
  logic sel_masked;
  logic sel_state;
  logic [31:0] be_mask;
  logic [31:0] rd_mux;
  logic [31:0] rdata_r;

  // Software visible storage.
  logic [31:0] cr_r;
  logic [31:0] cr_nxt;
  logic [31:0] cr_wm;
  logic [31:0] trig_r;
  logic [31:0] trig_nxt;
  logic [31:0] trig_wm;
  logic [31:0] mask_r;
  logic [31:0] mask_nxt;
  logic [31:0] mask_wm;
  logic [6:0] evt_r;
  logic [6:0] evt_nxt;
  logic [6:0] evt_clr;
  logic [6:0] evt_set;
  logic [6:0] mask_bits;
  logic [6:0] masked;
  uart_ctrl_pkg::ctrl_t ctrl;

  // Section run state and serial path.
  logic tx_want;
  logic rx_want;
  logic tx_run_r;
  logic tx_run_nxt;
  logic rx_run_r;
  logic rx_run_nxt;
  logic in_meta_r;
  logic in_sync_r;
  logic rx_serial_r;
  logic rx_serial_nxt;
  logic out_pin_r;
  logic out_pin_nxt;

  // FIFO trigger detection.
  uart_ctrl_pkg::fifo_view_t views [2];
  logic [1:0] level_hit;

  // ------------------------------------------------------------------
  // Avalon slave. Each access sees exactly one wait cycle, so read data
  // is captured while waitrequest is high and stands at the ack edge.
  // ------------------------------------------------------------------
  assign req = AVS_READ || AVS_WRITE;
  assign AVS_WAITREQUEST = req && (state_r == uart_ctrl_pkg::BUS_IDLE);
  assign fire = req && (state_r == uart_ctrl_pkg::BUS_ACK);
  assign wr_fire = fire && AVS_WRITE;
  // An acknowledged access always drops back to idle, so a request that is
  // still held afterwards is taken as a new access with its own wait cycle.
  always_comb
  begin
    case (state_r)
      uart_ctrl_pkg::BUS_IDLE:
      begin
        state_nxt = req ? uart_ctrl_pkg::BUS_ACK : uart_ctrl_pkg::BUS_IDLE;
      end
      default:
      begin
        state_nxt = uart_ctrl_pkg::BUS_IDLE;
      end
    endcase
  end

  assign word_addr = AVS_ADDRESS & `ADDR_WORD_MASK;
  assign sel_cr = (word_addr == `OFS_PORT_CONTROL);
  assign sel_trig = (word_addr == `OFS_TRIGGER_SEL);
  assign sel_mask = (word_addr == `OFS_INT_MASK);
  assign sel_evt = (word_addr == `OFS_EVT_STATUS);
  assign sel_masked = (word_addr == `OFS_MASKED_STATUS);
  assign sel_state = (word_addr == `OFS_SECTION_STATE);

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_lane
      assign be_mask[8*gb +: 8] = {8{AVS_BYTEENABLE[gb]}};
    end
  endgenerate

  // Unmapped addresses read as zero and ignore writes.
  // The selected word is sampled in the wait cycle and held in a register, so
  // the bus always sees a flip-flop output rather than this decode.
  // Status reads return the sticky events, not the raw error levels, so a
  // one-cycle error pulse is never lost between two polls.
  always_comb
  begin
    if (sel_cr)
    begin
      rd_mux = cr_r;
    end
    else if (sel_trig)
    begin
      rd_mux = trig_r;
    end
    else if (sel_mask)
    begin
      rd_mux = mask_r;
    end
    else if (sel_evt)
    begin
      rd_mux = {21'h00_0000, evt_r, 4'h0};
    end
    else if (sel_masked)
    begin
      rd_mux = {21'h00_0000, masked, 4'h0};
    end
    else if (sel_state)
    begin
      rd_mux = {28'h000_0000, rx_run_r, tx_run_r, RX_BUSY, TX_BUSY};
    end
    else
    begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r <= uart_ctrl_pkg::BUS_IDLE;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      if (AVS_WAITREQUEST)
      begin
        rdata_r <= rd_mux;
      end
    end
  end

  assign AVS_READDATA = rdata_r;

  // ------------------------------------------------------------------
  // Register writes honour byte enables; reserved bits stay zero.
  // ------------------------------------------------------------------
  assign cr_wm = (wr_fire && sel_cr) ? (be_mask & `CR_WMASK) : 32'h0000_0000;
  assign trig_wm = (wr_fire && sel_trig) ? (be_mask & `TRIG_WMASK) : 32'h0000_0000;
  assign mask_wm = (wr_fire && sel_mask) ? (be_mask & `INT_WMASK) : 32'h0000_0000;
  assign cr_nxt = (cr_r & ~cr_wm) | (AVS_WRITEDATA & cr_wm);
  assign trig_nxt = (trig_r & ~trig_wm) | (AVS_WRITEDATA & trig_wm);
  assign mask_nxt = (mask_r & ~mask_wm) | (AVS_WRITEDATA & mask_wm);

  // Configuration is not frozen while enabled; software is expected to
  // disable the port first, so a live change only risks one odd character.
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cr_r <= `CR_RESET;
      trig_r <= `TRIG_RESET;
      mask_r <= `MASK_RESET;
    end
    else
    begin
      cr_r <= cr_nxt;
      trig_r <= trig_nxt;
      mask_r <= mask_nxt;
    end
  end

  assign ctrl = '{
    rx_en: cr_r[`CR_RXE],
    tx_en: cr_r[`CR_TXE],
    loop: cr_r[`CR_LBE],
    mod_en: cr_r[`CR_EN]
  };

  // ------------------------------------------------------------------
  // Section enables. A section starts only when both its own enable and
  // the module enable are set, and once running it holds on through the
  // character in progress so a disable never truncates a frame.
  // ------------------------------------------------------------------
  // The busy inputs come from logic on this clock, so they need no synchroniser.
  assign tx_want = ctrl.mod_en && ctrl.tx_en;
  assign rx_want = ctrl.mod_en && ctrl.rx_en;
  assign tx_run_nxt = tx_want || (tx_run_r && TX_BUSY);
  assign rx_run_nxt = rx_want || (rx_run_r && RX_BUSY);

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_run_r <= 1'b0;
      rx_run_r <= 1'b0;
    end
    else
    begin
      tx_run_r <= tx_run_nxt;
      rx_run_r <= rx_run_nxt;
    end
  end

  assign TX_RUN = tx_run_r;
  assign RX_RUN = rx_run_r;

  // ------------------------------------------------------------------
  // Serial path. The pin is synchronised before use. In loopback the pin
  // idles high so the remote peer sees no traffic, and the receiver is
  // fed from the transmitter instead.
  // ------------------------------------------------------------------
  // Only the second stage is read, so a metastable first stage never
  // reaches the receiver.
  assign rx_serial_nxt = ctrl.loop ? TX_SERIAL : in_sync_r;
  assign out_pin_nxt = ctrl.loop ? 1'b1 : TX_SERIAL;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      in_meta_r <= 1'b1;
      in_sync_r <= 1'b1;
      rx_serial_r <= 1'b1;
      out_pin_r <= 1'b1;
    end
    else
    begin
      in_meta_r <= SERIAL_IN_PIN;
      in_sync_r <= in_meta_r;
      rx_serial_r <= rx_serial_nxt;
      out_pin_r <= out_pin_nxt;
    end
  end

  assign RX_SERIAL = rx_serial_r;
  assign SERIAL_OUT_PIN = out_pin_r;

  // ------------------------------------------------------------------
  // FIFO trigger points. Entry 0 watches receive filling upward, entry 1
  // watches transmit draining downward; levels count 0 to 16 entries.
  // ------------------------------------------------------------------
  assign views[0] = '{level: RX_LEVEL, sel: trig_r[`RXSEL_MSB:`RXSEL_LSB]};
  assign views[1] = '{level: TX_LEVEL, sel: trig_r[`TXSEL_MSB:`TXSEL_LSB]};

  genvar gf;
  generate
    for (gf = 0; gf < 2; gf++)
    begin : g_fifo
      level_cross u_cross
      (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .falling(gf == 1),
        .view(views[gf]),
        .hit_r(level_hit[gf])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Interrupt status. Bits line up with the mask: overrun at the top,
  // receive at the bottom. Error sources are levels from the receiver
  // and keep their bit set while they stay high.
  // ------------------------------------------------------------------
  assign evt_set = {ERR_RAW, level_hit[1], level_hit[0]};
  assign evt_clr = (wr_fire && sel_evt) ?
                   (AVS_WRITEDATA[`INT_MSB:`INT_LSB] & be_mask[`INT_MSB:`INT_LSB]) :
                   {`INT_W{1'b0}};
  // A new event in the clearing cycle survives the clear.
  assign evt_nxt = (evt_r & ~evt_clr) | evt_set;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      evt_r <= {`INT_W{1'b0}};
    end
    else
    begin
      evt_r <= evt_nxt;
    end
  end

  assign mask_bits = mask_r[`INT_MSB:`INT_LSB];
  assign masked = evt_r & mask_bits;
  assign MASKED_INT = masked;
  assign IRQ = |masked;

endmodule
`default_nettype wire

// ==== uart_ctrl_irq_asserts.sv ====
// Port assertions for the serial port control block.
`timescale 1ns/1ns
`default_nettype none
module uart_ctrl_irq_asserts
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic TX_BUSY,
  input wire logic RX_BUSY,
  input wire logic TX_RUN,
  input wire logic RX_RUN,
  input wire logic [4:0] TX_LEVEL,
  input wire logic [4:0] RX_LEVEL,
  input wire logic [4:0] ERR_RAW,
  input wire logic [6:0] MASKED_INT,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  sequence s_one_wait;
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endsequence
  property p_bus_wait;
    $rose(AVS_READ || AVS_WRITE) |-> s_one_wait;
  endproperty
  property p_irq_level;
    IRQ == (|MASKED_INT);
  endproperty
  property p_tx_start;
    $rose(TX_RUN) |-> $past(AVS_WRITE, 2);
  endproperty
  property p_rx_start;
    $rose(RX_RUN) |-> $past(AVS_WRITE, 2);
  endproperty
  property p_tx_finish;
    $fell(TX_RUN) |-> !$past(TX_BUSY);
  endproperty
  property p_rx_finish;
    $fell(RX_RUN) |-> !$past(RX_BUSY);
  endproperty
  // A mask write may expose an old event, so it excuses a rise as well.
  property p_rx_cross;
    $rose(MASKED_INT[0]) |-> $past(AVS_WRITE) || $past(RX_LEVEL, 2) > $past(RX_LEVEL, 3);
  endproperty
  property p_tx_cross;
    $rose(MASKED_INT[1]) |-> $past(AVS_WRITE) || $past(TX_LEVEL, 2) < $past(TX_LEVEL, 3);
  endproperty
  property p_err;
    $rose(MASKED_INT[6]) |-> $past(AVS_WRITE) || $past(ERR_RAW[4]);
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus wait not one cycle");
  a_irq_level: assert property (p_irq_level) else $error("irq level wrong");
  a_tx_start: assert property (p_tx_start) else $error("tx run rose alone");
  a_rx_start: assert property (p_rx_start) else $error("rx run rose alone");
  a_tx_finish: assert property (p_tx_finish) else $error("tx cut short");
  a_rx_finish: assert property (p_rx_finish) else $error("rx cut short");
  a_rx_cross: assert property (p_rx_cross) else $error("rx irq no cross");
  a_tx_cross: assert property (p_tx_cross) else $error("tx irq no cross");
  a_err: assert property (p_err) else $error("overrun irq no cause");
endmodule
bind uart_ctrl_irq uart_ctrl_irq_asserts chk (.CLK_SYS, .RST_N, .AVS_READ, .AVS_WRITE,
  .AVS_WAITREQUEST, .TX_BUSY, .RX_BUSY, .TX_RUN, .RX_RUN, .TX_LEVEL, .RX_LEVEL,
  .ERR_RAW, .MASKED_INT, .IRQ);
`default_nettype wire

// ==== line_peer.sv ====
// Remote serial peer that frames one byte onto the line.
`timescale 1ns/1ns
`default_nettype none
module line_peer
(
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] data,
  output logic pin
);
  logic [8:0] sh_r = 9'h1FF;
  logic [3:0] cnt_r = 4'h0;
  initial pin = 1'b1;
  // Between frames the line rests at mark, as a real idle peer would.
  always @(posedge clk)
  begin
    if (start)
    begin
      sh_r <= {data, 1'b0};
      cnt_r <= 4'h9;
    end
    else if (cnt_r != 4'h0)
    begin
      sh_r <= {1'b1, sh_r[8:1]};
      cnt_r <= cnt_r - 4'h1;
    end
    pin <= (cnt_r != 4'h0) ? sh_r[0] : 1'b1;
  end
endmodule
`default_nettype wire

// ==== uart_ctrl_irq_test.sv ====
// Self-checking bench for the serial port control block.
`timescale 1ns/1ns
`default_nettype none
module uart_ctrl_irq_test;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic [7:0] addr = 8'h00;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] be = 4'hF;
  logic tx_busy = 1'b0;
  logic rx_busy = 1'b0;
  logic tx_ser = 1'b1;
  logic [4:0] tx_lvl = 5'h00;
  logic [4:0] rx_lvl = 5'h00;
  logic [4:0] err = 5'h00;
  logic [31:0] rdata;
  logic wait_req, tx_run, rx_run, rx_ser, out_pin, irq, pin;
  logic [6:0] mint;
  logic p_go = 1'b0;
  logic chk_ser = 1'b0;
  logic loop = 1'b0;
  logic t_prev = 1'b1;
  logic [7:0] p_dat = 8'h00;
  logic [2:0] h = 3'h7;
  logic [31:0] seed = 32'h0001_42E3;
  logic [31:0] q, m, w;
  logic [31:0] cfg [3] = '{32'h0000_0300, 32'h0000_0101, 32'h0000_0201};
  int n_fail = 0;
  int n_checks = 0;
  int i;
  always #5 CLK_SYS = ~CLK_SYS;
  uart_ctrl_irq dut (.CLK_SYS, .RST_N, .AVS_ADDRESS(addr), .AVS_READ(rd_en),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .TX_BUSY(tx_busy), .RX_BUSY(rx_busy), .TX_RUN(tx_run),
    .RX_RUN(rx_run), .TX_SERIAL(tx_ser), .RX_SERIAL(rx_ser), .SERIAL_IN_PIN(pin),
    .SERIAL_OUT_PIN(out_pin), .TX_LEVEL(tx_lvl), .RX_LEVEL(rx_lvl), .ERR_RAW(err),
    .MASKED_INT(mint), .IRQ(irq));
  line_peer peer (.clk(CLK_SYS), .start(p_go), .data(p_dat), .pin(pin));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [4:0] lv(input int c);
    case (c)
      0: return 5'h02;
      1: return 5'h04;
      3: return 5'h0C;
      4: return 5'h0E;
      default: return 5'h08;
    endcase
  endfunction
  function automatic logic [1:0] runs(input logic [31:0] c);
    return {c[8] & c[0], c[9] & c[0]};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    rd_en <= !wr;
    wr_en <= wr;
    addr <= a;
    wdata <= d;
    @(posedge CLK_SYS);
    while (wait_req !== 1'b0)
      @(posedge CLK_SYS);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(posedge CLK_SYS);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    ck(q, e);
  endtask
  always @(posedge CLK_SYS)
  begin
    if (chk_ser)
    begin
      ck(rx_ser, loop ? t_prev : h[2]);
      ck(out_pin, loop ? 1'b1 : t_prev);
    end
    h <= {h[1:0], pin};
    t_prev <= tx_ser;
  end
  // The whole sequence needs a few hundred cycles; this margin only cuts a hang.
  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end
  initial
  begin
    repeat (8) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    @(posedge CLK_SYS);
    ck({tx_run, rx_run, irq}, 3'h0);
    rc(8'h30, 32'h0000_0300);
    rc(8'h34, 32'h0000_0012);
    rc(8'h38, 32'h0000_0000);
    rc(8'h3C, 32'h0000_0000);
    for (i = 0; i < 4; i++)
    begin
      m = rnd();
      bus(1'b1, 8'h38, m);
      rc(8'h38, m & 32'h0000_07F0);
    end
    be <= 4'h1;
    bus(1'b1, 8'h38, 32'hFFFF_FFFF);
    be <= 4'hF;
    rc(8'h38, (m & 32'h0000_0700) | 32'h0000_00F0);
    for (i = 0; i < 3; i++)
    begin
      bus(1'b1, 8'h30, 32'h0000_0301);
      tx_busy <= 1'b1;
      rx_busy <= 1'b1;
      bus(1'b1, 8'h30, cfg[i]);
      repeat (3) @(posedge CLK_SYS);
      ck({tx_run, rx_run}, 2'h3);
      rc(8'h50, 32'h0000_000F);
      tx_busy <= 1'b0;
      rx_busy <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      ck({tx_run, rx_run}, runs(cfg[i]));
    end
    bus(1'b1, 8'h30, 32'h0000_0380);
    loop <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    chk_ser <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      m = rnd();
      tx_ser <= m[0];
      @(posedge CLK_SYS);
    end
    chk_ser <= 1'b0;
    bus(1'b1, 8'h30, 32'h0000_0300);
    loop <= 1'b0;
    repeat (4) @(posedge CLK_SYS);
    chk_ser <= 1'b1;
    p_dat <= m[15:8];
    p_go <= 1'b1;
    @(posedge CLK_SYS);
    p_go <= 1'b0;
    repeat (14) @(posedge CLK_SYS);
    chk_ser <= 1'b0;
    bus(1'b1, 8'h38, 32'h0000_07F0);
    for (i = 0; i < 6; i++)
    begin
      bus(1'b1, 8'h34, {26'h000_0000, i[2:0], i[2:0]});
      rx_lvl <= lv(i) - 5'h01;
      tx_lvl <= lv(i) + 5'h01;
      repeat (3) @(posedge CLK_SYS);
      bus(1'b1, 8'h48, 32'h0000_0030);
      rx_lvl <= lv(i);
      tx_lvl <= lv(i);
      repeat (3) @(posedge CLK_SYS);
      ck(irq, i < 5);
      rc(8'h48, (i < 5) ? 32'h0000_0030 : 32'h0000_0000);
      bus(1'b1, 8'h48, 32'h0000_0030);
      repeat (3) @(posedge CLK_SYS);
      rc(8'h48, 32'h0000_0000);
      rx_lvl <= 5'h00;
      tx_lvl <= 5'h00;
    end
    for (i = 0; i < 5; i++)
    begin
      m = (i == 0) ? 32'h0000_0000 : (rnd() & 32'h0000_07F0);
      bus(1'b1, 8'h38, m);
      q = rnd() | 32'h0000_0010;
      err <= q[4:0];
      w = {21'h00_0000, q[4:0] & m[10:6], 6'h00};
      @(posedge CLK_SYS);
      err <= 5'h00;
      repeat (2) @(posedge CLK_SYS);
      ck({irq, mint}, {|w, w[10:4]});
      rc(8'h4C, w);
      bus(1'b1, 8'h48, 32'h0000_07F0);
    end
    final_report();
  end
endmodule
`default_nettype wire
